/* design/lfh_flash_dev.sv */
// Flash front end: framing, chip select, input pin register, port mode.
// Assumes the host keeps to the link timing of lfh_pkg on clk_i.
module lfh_flash_dev (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Board straps and pins
  input wire logic [lfh_pkg::STRAP_W-1:0] chip_select_straps_i,
  input wire logic [lfh_pkg::GIN_W-1:0] general_input_pins_i,
  input wire logic interface_select_i,
  // Status
  output logic mux_mode_o,
  output logic reset_mode_o,
  output logic busy_o,
  // Link
  lfh_link_if.device link
);
  import lfh_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic rst_int;
  logic mux_mode;
  logic hit;
  logic frame_low;
  lfh_dev_state_t state;
  lfh_dev_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic is_write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [MEM_IDX_W-1:0] idx;
  logic mem_space;
  logic [NIB_W-1:0] lad_out;
  logic lad_oe;

  ////////////////////////////////////////////////////////////////////////
  // Reset and port mode
  // Any of the three reset inputs low (nrst_i or either link reset) holds the block in reset mode
  assign rst_int = !nrst_i || !link.port_reset_n || !link.cpu_reset_n;

  // Tracks the select pin only while in reset, frozen afterwards
  always_ff @(posedge clk_i) begin
    if (rst_int) begin
      mux_mode <= interface_select_i;
    end
  end

  always_ff @(posedge clk_i) begin
    reset_mode_o <= rst_int;
    mux_mode_o <= mux_mode;
  end

  ////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  assign frame_low = !link.lframe_n;
  assign idx = addr[MEM_IDX_W-1:0];
  assign mem_space = addr[MEM_SPACE_BIT];

  lfh_strap_match #(
    .W(STRAP_W)
  ) u_match (
    .addr_bits_i(addr[STRAP_LSB +: STRAP_W]),
    .straps_i(chip_select_straps_i),
    .match_o(hit)
  );

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (rst_int || mux_mode) begin
      // Programmer port mode leaves the link side silent
      next_state = D_IDLE;
      next_cnt = CNT_ZERO;
    end else if (frame_low) begin
      next_cnt = CNT_ZERO;
      if (link.lad == START_NIB) begin
        next_state = D_CT;
      end else begin
        next_state = D_IDLE;
      end
    end else begin
      unique case (state)
        D_IDLE: begin
          next_state = D_IDLE;
        end
        D_CT: begin
          if (link.lad == CT_READ || link.lad == CT_WRITE) begin
            next_state = D_ADDR;
          end else begin
            next_state = D_IDLE;
          end
        end
        D_ADDR: begin
          if (cnt == ADDR_LAST) begin
            next_cnt = CNT_ZERO;
            next_state = is_write ? D_WDATA : D_TAR;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        D_WDATA: begin
          if (cnt == DATA_LAST) begin
            next_cnt = CNT_ZERO;
            next_state = D_TAR;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        D_TAR: begin
          if (cnt == TAR_LAST) begin
            next_cnt = CNT_ZERO;
            // Unselected memory drops out and never drives
            next_state = hit ? D_SYNC : D_IDLE;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        D_SYNC: begin
          next_cnt = CNT_ZERO;
          next_state = is_write ? D_TARB : D_RDATA;
        end
        D_RDATA: begin
          if (cnt == DATA_LAST) begin
            next_cnt = CNT_ZERO;
            next_state = D_TARB;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        D_TARB: begin
          if (cnt == TAR_LAST) begin
            next_cnt = CNT_ZERO;
            next_state = D_IDLE;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
    cnt <= next_cnt;
    busy_o <= (next_state != D_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // Captured fields
  always_ff @(posedge clk_i) begin
    if (state == D_CT) begin
      is_write <= (link.lad == CT_WRITE);
    end
  end

  // Address arrives most significant nibble first
  always_ff @(posedge clk_i) begin
    if (state == D_ADDR) begin
      addr <= {addr[ADDR_W-NIB_W-1:0], link.lad};
    end
  end

  // Data arrives low nibble first
  always_ff @(posedge clk_i) begin
    if (state == D_WDATA) begin
      wdata <= {link.lad, wdata[DATA_W-1:NIB_W]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array and input pin register
  always_comb begin
    read_value = UNMAPPED_DATA;
    if (mem_space) begin
      read_value = mem[idx];
    end else if (idx == GIN_REG_OFS) begin
      read_value = {{(DATA_W-GIN_W){1'b0}}, general_input_pins_i};
    end
  end

  // Pins are sampled once per read, when the sync is issued
  always_ff @(posedge clk_i) begin
    if (next_state == D_SYNC) begin
      rdata <= read_value;
    end
  end

  // Contents survive the pin resets; only power-up reset erases.
  // Programming can only clear bits, as in a real cell.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (state == D_SYNC && is_write && mem_space) begin
      mem[idx] <= mem[idx] & wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link drivers
  always_ff @(posedge clk_i) begin
    lad_oe <= 1'b0;
    lad_out <= IDLE_NIB;
    unique case (next_state)
      D_SYNC: begin
        lad_oe <= 1'b1;
        lad_out <= SYNC_READY;
      end
      D_RDATA: begin
        lad_oe <= 1'b1;
        if (next_cnt == CNT_ZERO) begin
          lad_out <= rdata[NIB_W-1:0];
        end else begin
          lad_out <= rdata[DATA_W-1:NIB_W];
        end
      end
      D_TARB: begin
        // Drive high for one cycle, then release
        lad_oe <= (next_cnt == CNT_ZERO);
        lad_out <= TAR_NIB;
      end
      D_IDLE, D_CT, D_ADDR, D_WDATA, D_TAR: begin
        lad_oe <= 1'b0;
      end
    endcase
  end

  assign link.dev_lad_out = lad_out;
  assign link.dev_lad_oe = lad_oe;
endmodule

/* design/lfh_host.sv */
// Host controller end: issues framed reads and writes, aborts on demand.
// Assumes the flash end shares clk_i; a missing sync times out.
module lfh_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [lfh_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [lfh_pkg::DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  // Control
  input wire logic abort_i,
  input wire logic cpu_reset_i,
  // Answer
  output logic done_o,
  output logic no_answer_o,
  output logic [lfh_pkg::DATA_W-1:0] rdata_o,
  // Link
  lfh_link_if.host link
);
  import lfh_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  lfh_host_state_t state;
  lfh_host_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [WAIT_W-1:0] wait_cnt;
  logic is_write;
  logic [ADDR_W-1:0] addr_sh;
  logic [DATA_W-1:0] wdata;
  logic timeout;
  logic last_tarb;

  assign req_ready_o = nrst_i && (state == H_IDLE);
  assign timeout = (state == H_SYNC) && (link.lad != SYNC_READY) &&
                   (wait_cnt == SYNC_WAIT_LAST);
  assign last_tarb = (state == H_TARB) && (cnt == TAR_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (!nrst_i) begin
      next_state = H_IDLE;
      next_cnt = CNT_ZERO;
    end else if (abort_i && state != H_IDLE && state != H_ABORT) begin
      next_state = H_ABORT;
      next_cnt = CNT_ZERO;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (req_valid_i) begin
            next_state = H_START;
          end
        end
        H_START: begin
          next_state = H_CT;
        end
        H_CT: begin
          next_state = H_ADDR;
          next_cnt = CNT_ZERO;
        end
        H_ADDR: begin
          if (cnt == ADDR_LAST) begin
            next_cnt = CNT_ZERO;
            next_state = is_write ? H_WDATA : H_TAR;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        H_WDATA: begin
          if (cnt == DATA_LAST) begin
            next_cnt = CNT_ZERO;
            next_state = H_TAR;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        H_TAR: begin
          if (cnt == TAR_LAST) begin
            next_cnt = CNT_ZERO;
            next_state = H_SYNC;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        H_SYNC: begin
          if (link.lad == SYNC_READY) begin
            next_state = is_write ? H_TARB : H_RDATA;
          end else if (timeout) begin
            next_state = H_ABORT;
          end
        end
        H_RDATA: begin
          if (cnt == DATA_LAST) begin
            next_cnt = CNT_ZERO;
            next_state = H_TARB;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        H_TARB, H_ABORT: begin
          if (cnt == ((state == H_ABORT) ? ABORT_LAST : TAR_LAST)) begin
            next_cnt = CNT_ZERO;
            next_state = H_IDLE;
          end else begin
            next_cnt = cnt + CNT_STEP;
          end
        end
        default: begin
          next_state = H_IDLE;
          next_cnt = CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
    cnt <= next_cnt;
  end

  always_ff @(posedge clk_i) begin
    if (state != H_SYNC) begin
      wait_cnt <= WAIT_ZERO;
    end else begin
      wait_cnt <= wait_cnt + WAIT_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request capture and answers
  always_ff @(posedge clk_i) begin
    if (state == H_IDLE && next_state == H_START) begin
      is_write <= req_write_i;
      addr_sh <= req_addr_i;
      wdata <= req_wdata_i;
    end else if (next_state == H_ADDR) begin
      addr_sh <= {addr_sh[ADDR_W-NIB_W-1:0], {NIB_W{1'b0}}};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= UNMAPPED_DATA;
    end else if (state == H_RDATA) begin
      rdata_o <= {link.lad, rdata_o[DATA_W-1:NIB_W]};
    end
  end

  always_ff @(posedge clk_i) begin
    done_o <= nrst_i && last_tarb;
    no_answer_o <= nrst_i && timeout;
  end

  ////////////////////////////////////////////////////////////////////////
  // Link drivers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      link.port_reset_n <= 1'b0;
    end else begin
      link.port_reset_n <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    link.cpu_reset_n <= !cpu_reset_i;
  end

  always_ff @(posedge clk_i) begin
    link.lframe_n <= 1'b1;
    link.host_lad_oe <= 1'b0;
    link.host_lad_out <= IDLE_NIB;
    unique case (next_state)
      H_START: begin
        link.lframe_n <= 1'b0;
        link.host_lad_oe <= 1'b1;
        link.host_lad_out <= START_NIB;
      end
      H_CT: begin
        link.host_lad_oe <= 1'b1;
        link.host_lad_out <= is_write ? CT_WRITE : CT_READ;
      end
      H_ADDR: begin
        link.host_lad_oe <= 1'b1;
        link.host_lad_out <= addr_sh[ADDR_W-1 -: NIB_W];
      end
      H_WDATA: begin
        link.host_lad_oe <= 1'b1;
        if (next_cnt == CNT_ZERO) begin
          link.host_lad_out <= wdata[NIB_W-1:0];
        end else begin
          link.host_lad_out <= wdata[DATA_W-1:NIB_W];
        end
      end
      H_TAR: begin
        link.host_lad_oe <= (next_cnt == CNT_ZERO);
        link.host_lad_out <= TAR_NIB;
      end
      H_ABORT: begin
        link.lframe_n <= 1'b0;
        link.host_lad_oe <= 1'b1;
        link.host_lad_out <= ABORT_NIB;
      end
      default: begin
        link.lframe_n <= 1'b1;
      end
    endcase
  end
endmodule

/* design/lfh_link_if.sv */
// Link between host controller and flash front end.
// The nibble bus is resolved here from both enables; idle level is high.
interface lfh_link_if;
  import lfh_pkg::*;
  logic lframe_n;
  logic [NIB_W-1:0] host_lad_out;
  logic host_lad_oe;
  logic [NIB_W-1:0] dev_lad_out;
  logic dev_lad_oe;
  logic [NIB_W-1:0] lad;
  logic port_reset_n;
  logic cpu_reset_n;

  // Pull-up keeps an undriven bus at all ones
  assign lad = host_lad_oe ? host_lad_out :
               dev_lad_oe ? dev_lad_out : IDLE_NIB;

  modport host (
    output lframe_n,
    output host_lad_out,
    output host_lad_oe,
    output port_reset_n,
    output cpu_reset_n,
    input lad
  );
  modport device (
    input lframe_n,
    input lad,
    input port_reset_n,
    input cpu_reset_n,
    output dev_lad_out,
    output dev_lad_oe
  );
endinterface

/* design/lfh_pkg.sv */
// Shared constants and link field codes for the flash front end.
// Assumes one common bus clock for both ends of the link.
package lfh_pkg;
  localparam int NIB_W = 4;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 24;
  localparam int STRAP_W = 2;
  localparam int GIN_W = 5;
  localparam int CNT_W = 3;
  localparam int WAIT_W = 4;
  localparam int MEM_IDX_W = 4;
  localparam int MEM_DEPTH = 16;

  // Address layout
  localparam int STRAP_LSB = 20;
  localparam int MEM_SPACE_BIT = 22;

  // Nibble codes on the link
  localparam logic [NIB_W-1:0] START_NIB = 4'h0;
  localparam logic [NIB_W-1:0] ABORT_NIB = 4'hf;
  localparam logic [NIB_W-1:0] CT_READ = 4'h0;
  localparam logic [NIB_W-1:0] CT_WRITE = 4'h2;
  localparam logic [NIB_W-1:0] TAR_NIB = 4'hf;
  localparam logic [NIB_W-1:0] SYNC_READY = 4'h0;
  localparam logic [NIB_W-1:0] IDLE_NIB = 4'hf;

  // Phase lengths, as the last value of the phase counter
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;
  localparam logic [CNT_W-1:0] ADDR_LAST = 3'h5;
  localparam logic [CNT_W-1:0] DATA_LAST = 3'h1;
  localparam logic [CNT_W-1:0] TAR_LAST = 3'h1;
  localparam logic [CNT_W-1:0] ABORT_LAST = 3'h3;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
  localparam logic [WAIT_W-1:0] WAIT_STEP = 4'h1;
  localparam logic [WAIT_W-1:0] SYNC_WAIT_LAST = 4'h7;

  // Register space and data values
  localparam logic [MEM_IDX_W-1:0] GIN_REG_OFS = 4'h1;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'hff;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_CT = 3'h1,
    D_ADDR = 3'h3,
    D_WDATA = 3'h2,
    D_TAR = 3'h6,
    D_SYNC = 3'h7,
    D_RDATA = 3'h5,
    D_TARB = 3'h4
  } lfh_dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0,
    H_START = 4'h1,
    H_CT = 4'h3,
    H_ADDR = 4'h2,
    H_WDATA = 4'h6,
    H_TAR = 4'h7,
    H_SYNC = 4'h5,
    H_RDATA = 4'h4,
    H_TARB = 4'hc,
    H_ABORT = 4'hd
  } lfh_host_state_t;
endpackage

/* design/lfh_strap_match.sv */
// Compares address bits against board straps with inverted sense.
// Assumes straps are static levels.
module lfh_strap_match #(
  parameter int W = 2
) (
  // Compared values
  input wire logic [W-1:0] addr_bits_i,
  input wire logic [W-1:0] straps_i,
  // Result
  output logic match_o
);
  // A low strap selects an address bit of one
  assign match_o = (addr_bits_i == ~straps_i);
endmodule

/* test/lfh_link_monitor.sv */
// Concurrent checks on the nibble link between host and flash front end.
// Assumes one clock and a synchronous active-low reset on nrst_i.
module lfh_link_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Link signals
  input wire logic lframe_n,
  input wire logic [lfh_pkg::NIB_W-1:0] lad,
  input wire logic host_lad_oe,
  input wire logic dev_lad_oe,
  input wire logic port_reset_n,
  input wire logic cpu_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import lfh_pkg::*;

  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Saturates so a long idle never wraps back into a legal answer window
  logic [4:0] since_start;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      since_start <= 5'h1f;
    end else if (!lframe_n && lad == START_NIB) begin
      since_start <= 5'h01;
    end else if (since_start != 5'h1f) begin
      since_start <= since_start + 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  chk_drive_window:
    assert property (dev_lad_oe |-> since_start >= 5'h0a
                     && since_start <= 5'h0d)
    else $error("device drives outside the answer window");
  chk_abort_quiet:
    assert property (!lframe_n && lad != START_NIB |=> (!dev_lad_oe) [*8])
    else $error("device drives after an abort");
  chk_sync_first:
    assert property ($rose(dev_lad_oe) |-> lad == SYNC_READY
                     && !$past(host_lad_oe))
    else $error("device answer does not open with sync");
  chk_release_idle:
    assert property ($fell(dev_lad_oe) && $past(lframe_n)
                     && $past(port_reset_n) && $past(cpu_reset_n)
                     |-> $past(lad) == IDLE_NIB)
    else $error("device releases link without idle nibble");
  chk_drive_bound:
    assert property (dev_lad_oe [*4] |=> !dev_lad_oe)
    else $error("device drives link too long");
  chk_no_contend:
    assert property (dev_lad_oe && lframe_n |-> !host_lad_oe)
    else $error("both ends drive the link");
  chk_port_reset_quiet:
    assert property (!port_reset_n |=> (!dev_lad_oe) [*3])
    else $error("device drives link during port reset");
  chk_cpu_reset_quiet:
    assert property (!cpu_reset_n |=> (!dev_lad_oe) [*3])
    else $error("device drives link during cpu reset");
endmodule

/* test/tb_top.sv */
// Testbench joining host controller and flash front end over the link.
// Assumes lfh_pkg, the link interface and both ends are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lfh_pkg::*;

  logic clk_i = 1'b0;
  logic nrst_i;
  logic [STRAP_W-1:0] straps;
  logic [GIN_W-1:0] pins;
  logic isel;
  logic req_valid;
  logic req_write;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata;
  logic req_ready;
  logic abort;
  logic cpu_rst;
  logic done;
  logic no_answer;
  logic [DATA_W-1:0] rdata;
  logic mux_mode;
  logic reset_mode;
  logic busy;
  logic [DATA_W-1:0] rd;
  logic [1:0] res;
  logic seen;
  int errors = 0;
  int n_compared = 0;

  always #10 clk_i = ~clk_i;

  lfh_link_if link();

  lfh_host i_lfh_host (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .req_valid_i(req_valid),
    .req_write_i(req_write),
    .req_addr_i(req_addr),
    .req_wdata_i(req_wdata),
    .req_ready_o(req_ready),
    .abort_i(abort),
    .cpu_reset_i(cpu_rst),
    .done_o(done),
    .no_answer_o(no_answer),
    .rdata_o(rdata),
    .link(link)
  );

  lfh_flash_dev i_lfh_flash_dev (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .chip_select_straps_i(straps),
    .general_input_pins_i(pins),
    .interface_select_i(isel),
    .mux_mode_o(mux_mode),
    .reset_mode_o(reset_mode),
    .busy_o(busy),
    .link(link)
  );

  lfh_link_monitor i_lfh_link_monitor (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .lframe_n(link.lframe_n),
    .lad(link.lad),
    .host_lad_oe(link.host_lad_oe),
    .dev_lad_oe(link.dev_lad_oe),
    .port_reset_n(link.port_reset_n),
    .cpu_reset_n(link.cpu_reset_n)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Request is a level held until the edge that takes it
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    // A host that never frees up counts as a failure, not a silent retry
    if (req_ready !== 1'b1) begin
      check({7'h0, req_ready}, 8'h1);
    end
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    req_valid = 1'b1;
    @(negedge clk_i);
    req_valid = 1'b0;
  endtask

  // res: 1 completed, 2 no answer, 0 nothing seen
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd);
    int n;
    issue(wr, a, wd);
    res = 2'h0;
    n = 0;
    while (res == 2'h0 && n < 40) begin
      @(negedge clk_i);
      n++;
      if (done === 1'b1) begin
        res = 2'h1;
      end else if (no_answer === 1'b1) begin
        res = 2'h2;
      end
    end
    // Neither pulse seen: the limit ran out, which is a mismatch
    if (res == 2'h0) begin
      check({6'h0, res}, 8'h1);
    end
    rd = rdata;
  endtask

  task automatic cpu_pulse(input logic sel);
    isel = sel;
    cpu_rst = 1'b1;
    repeat (4) @(negedge clk_i);
    check({7'h0, reset_mode}, 8'h1);
    check({7'h0, link.dev_lad_oe}, 8'h0);
    cpu_rst = 1'b0;
    repeat (4) @(negedge clk_i);
    check({7'h0, reset_mode}, 8'h0);
    check({7'h0, mux_mode}, {7'h0, sel});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    conclude();
  end

  initial begin
    nrst_i = 1'b0;
    straps = 2'h0;
    pins = 5'h15;
    isel = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 24'h0;
    req_wdata = 8'h0;
    abort = 1'b0;
    cpu_rst = 1'b0;
    repeat (10) @(negedge clk_i);
    check({7'h0, reset_mode}, 8'h1);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check({7'h0, reset_mode}, 8'h0);
    check({7'h0, mux_mode}, 8'h0);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, {20'h70000, i[3:0]}, 8'h0);
      check({6'h0, res}, 8'h1);
      check(rd, 8'hff);
    end
    xfer(1'b1, 24'h700003, 8'h5a);
    check({6'h0, res}, 8'h1);
    xfer(1'b0, 24'h700003, 8'h0);
    check(rd, 8'h5a);
    for (int i = 0; i < 2; i++) begin
      pins = (i == 0) ? 5'h0a : 5'h15;
      xfer(1'b0, 24'h300001, 8'h0);
      check(rd, {3'h0, pins});
    end
    // Register space away from the pin register reads all ones
    xfer(1'b0, 24'h300005, 8'h0);
    check({6'h0, res}, 8'h1);
    check(rd, 8'hff);
    // Every strap setting: matching address answers, the inverse does not
    for (int i = 0; i < 4; i++) begin
      straps = i[1:0];
      xfer(1'b0, {2'h1, ~straps, 20'h00003}, 8'h0);
      check({6'h0, res}, 8'h1);
      check(rd, 8'h5a);
      xfer(1'b0, {2'h1, straps, 20'h00003}, 8'h0);
      check({6'h0, res}, 8'h2);
    end
    straps = 2'h0;
    issue(1'b0, 24'h700003, 8'h0);
    repeat (4) @(negedge clk_i);
    check({7'h0, busy}, 8'h1);
    abort = 1'b1;
    @(negedge clk_i);
    abort = 1'b0;
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk_i);
      seen = seen | (done === 1'b1);
    end
    check({7'h0, seen}, 8'h0);
    check({7'h0, busy}, 8'h0);
    xfer(1'b0, 24'h700003, 8'h0);
    check({6'h0, res}, 8'h1);
    check(rd, 8'h5a);
    cpu_pulse(1'b1);
    xfer(1'b0, 24'h700003, 8'h0);
    check({6'h0, res}, 8'h2);
    // A late change of the select level must not switch ports
    isel = 1'b0;
    repeat (3) @(negedge clk_i);
    check({7'h0, mux_mode}, 8'h1);
    xfer(1'b0, 24'h700003, 8'h0);
    check({6'h0, res}, 8'h2);
    cpu_pulse(1'b0);
    xfer(1'b0, 24'h700003, 8'h0);
    check({6'h0, res}, 8'h1);
    check(rd, 8'h5a);
    nrst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check({7'h0, busy}, 8'h0);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    xfer(1'b0, 24'h700003, 8'h0);
    // The read must really answer: rdata also resets to all ones
    check({6'h0, res}, 8'h1);
    check(rd, 8'hff);
    conclude();
  end
endmodule
